// ===== logic/cljm_motion.sv
// closed loop target, index homing and open loop jog motion core
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "cljm_defines.svh"
module cljm_motion #(
	parameter int LOOP_CYCLES = `CLJM_LOOP_CYC,
	parameter int SLOW_CYCLES = `CLJM_SLOW_CYC
) (
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	input  wire logic        QUAD_A,
	input  wire logic        QUAD_B,
	input  wire logic        QUAD_I,
	input  wire logic [31:0] ENC_WORD,
	input  wire logic        ENC_WORD_VALID,
	input  wire logic [15:0] CAP_NF,
	input  wire logic [14:0] FREQ_HZ,
	input  wire logic        WAVE_RHOMB,
	input  wire logic [7:0]  IO_PINS,
	output logic             MICRO_STEP,
	output logic             MOTOR_DIR,
	output logic             MOTOR_RUN,
	output logic             TARGET_MODE
);

	cljm_pkg::cljm_state_s s;
	cljm_pkg::cljm_state_s n;

	logic [3:0]  qx;
	logic        qup;
	logic        qdn;
	logic        irise;
	logic [19:0] period;
	logic [31:0] err;
	logic [63:0] prod;
	logic [31:0] dem;
	logic [31:0] mag;
	logic [31:0] stp;
	logic [31:0] tot;
	logic [31:0] spd;
	logic [31:0] r2;
	logic [31:0] dd;
	logic [15:0] digits;

	// -----------------------------------------------------------
	// next state
	// -----------------------------------------------------------
	always_comb begin
		n = s;
		qx = {s.pab, s.sy2[2:1]};
		qup = 1'b0;
		qdn = 1'b0;
		irise = s.sy2[0] & ~s.pidx;
		period = (s.enctype == `CLJM_ENC_SLOW) ? SLOW_CYCLES[19:0] : LOOP_CYCLES[19:0];
		err = s.target - s.pos;
		prod = $signed(err) * $signed({32'h0000_0000, s.microsteps_per_encoder_count});
		dem = prod[`CLJM_SPC_SHIFT +: 32];
		mag = dem[31] ? (32'h0000_0000 - dem) : dem;
		stp = 32'h0000_0000;
		tot = {s.jwfm[18:0], 13'h0000} + s.jmicro;
		spd = s.jspeed[31] ? (32'h0000_0000 - s.jspeed) : s.jspeed;
		r2 = {s.dr[30:0], s.dcnt == `CLJM_DIV_MSB};
		dd = s.pos - s.p0;
		digits = {4'h0, 2'b00, s.sc != cljm_pkg::SC_IDLE, s.ifresh,
			1'b0, s.tlimit, s.tmode, s.treached, 2'b00, s.dir, s.run};
		n.step = 1'b0;
		n.rdata = 32'h0000_0000;

		// synchronisers; only the second stage is looked at
		n.sy1 = {QUAD_A, QUAD_B, QUAD_I};
		n.sy2 = s.sy1;
		n.pab = s.sy2[2:1];
		n.pidx = s.sy2[0];

		// quadrature decode, one count per valid edge
		case (qx)
			4'b0001, 4'b0111, 4'b1110, 4'b1000: qup = 1'b1;
			4'b0010, 4'b1011, 4'b1101, 4'b0100: qdn = 1'b1;
			default: ;
		endcase

		// position source follows the encoder type
		if (s.enctype == `CLJM_ENC_QUAD) begin
			if (qup ^ s.encdir && (qup | qdn))
				n.pos = s.pos + 32'h0000_0001;
			else if (qup | qdn)
				n.pos = s.pos - 32'h0000_0001;
		end else if (ENC_WORD_VALID) begin
			n.pos = ENC_WORD;
		end

		// index events
		if (irise)
			n.ipos = s.pos;
		if (s.imode == `CLJM_IDX_RESET && s.sy2 == 3'b111) begin
			n.pos = s.qoff;
			n.imode = `CLJM_IDX_DONE;
			n.ifound = 1'b1;
			n.rem = 32'h0000_0000;
		end
		if (s.imode == `CLJM_IDX_STOP && irise && !s.ifound) begin
			n.ifound = 1'b1;
			n.rem = 32'h0000_0000;
		end

		// loop tick, 1 ms or 2 ms
		n.tick = (s.tick >= period - 20'h00001) ? 20'h00000 : s.tick + 20'h00001;

		// closed loop iteration
		if (s.tmode && s.tick == 20'h00000) begin
			if ($signed(s.pos) < $signed(s.lower) || $signed(s.pos) > $signed(s.upper)) begin
				n.tmode = 1'b0;
				n.tlimit = 1'b1;
				n.rem = 32'h0000_0000;
				n.vel = 32'h0000_0000;
			end else begin
				// speed up by accel, back off by decel near target
				if (mag < s.vel)
					n.vel = (s.vel - mag > {16'h0000, s.decel})
						? s.vel - {16'h0000, s.decel} : mag;
				else
					n.vel = s.vel + {16'h0000, s.accel};
				stp = (mag < n.vel) ? mag : n.vel;
				// slowdown halves the step count of every loop iteration, per direction
				if ((s.slow[0] && !err[31]) || (s.slow[1] && err[31]))
					stp = {1'b0, stp[31:1]};
				n.rem = stp;
				n.dir = err[31];
				n.treached = (err == 32'h0000_0000);
			end
		end

		// microstep generator
		if (s.rem != 32'h0000_0000) begin
			if (s.tmode) begin
				n.step = 1'b1;
				n.rem = n.rem - 32'h0000_0001;
			end else begin
				n.acc = s.acc + {3'b000, s.rate, 13'h0000};
				if (n.acc >= `CLJM_STEP_THRESH) begin
					n.acc = n.acc - `CLJM_STEP_THRESH;
					n.step = 1'b1;
					n.rem = n.rem - 32'h0000_0001;
				end
			end
		end else begin
			n.acc = 32'h0000_0000;
		end
		n.run = (n.rem != 32'h0000_0000);

		// auto configuration script
		case (s.sc)
			cljm_pkg::SC_FWD: begin
				if (s.rem == 32'h0000_0000) begin
					n.dmag = dd;
					n.rem = `CLJM_SCRIPT_USTEPS;
					n.dir = 1'b1;
					n.sc = cljm_pkg::SC_REV;
				end
			end
			cljm_pkg::SC_REV: begin
				if (s.rem == 32'h0000_0000) begin
					if (s.dmag == 32'h0000_0000) begin
						n.scstat = 8'hFF;
						n.microsteps_per_encoder_count = `CLJM_SPC_FAIL;
						n.sc = cljm_pkg::SC_IDLE;
					end else begin
						n.encdir = s.encdir ^ s.dmag[31];
						n.dmag = s.dmag[31] ? 32'h0000_0000 - s.dmag : s.dmag;
						n.dr = 32'h0000_0000;
						n.dq = 32'h0000_0000;
						n.dcnt = `CLJM_DIV_MSB;
						n.sc = cljm_pkg::SC_CALC;
					end
				end
			end
			cljm_pkg::SC_CALC: begin
				// restoring divide of 65536*4*16 by the count change
				if (r2 >= s.dmag) begin
					n.dr = r2 - s.dmag;
					n.dq = {s.dq[30:0], 1'b1};
				end else begin
					n.dr = r2;
					n.dq = {s.dq[30:0], 1'b0};
				end
				n.dcnt = s.dcnt - 5'd1;
				if (s.dcnt == 5'd0) begin
					n.microsteps_per_encoder_count = n.dq;
					n.scstat = 8'h00;
					n.sc = cljm_pkg::SC_IDLE;
				end
			end
			default: ;
		endcase

		// -------------------------------------------------------
		// register writes; software wins over the events above
		// -------------------------------------------------------
		if (WR) begin
			case (ADDR)
				`CLJM_A_CMD: begin
					case (WDATA[2:0])
						`CLJM_CMD_ABS, `CLJM_CMD_REL, `CLJM_CMD_CONT: begin
							n.tmode = 1'b1;
							n.tlimit = 1'b0;
							n.vel = 32'h0000_0000;
							if (WDATA[2:0] == `CLJM_CMD_REL)
								n.target = s.pos + s.target;
							else if (WDATA[2:0] == `CLJM_CMD_CONT)
								n.target = s.target[31] ? s.lower : s.upper;
						end
						`CLJM_CMD_STOP: begin
							n.tmode = 1'b0;
							n.rem = 32'h0000_0000;
						end
						`CLJM_CMD_JOG, `CLJM_CMD_IJOG: begin
							n.tmode = 1'b0;
							if (WDATA[2:0] == `CLJM_CMD_JOG || (!s.ifound
								&& (s.imode == `CLJM_IDX_STOP
								|| s.imode == `CLJM_IDX_RESET))) begin
								n.rem = tot[31] ? 32'h0000_0000 - tot : tot;
								n.dir = tot[31] ^ s.jspeed[31];
								n.rate = spd[15:0];
								n.acc = 32'h0000_0000;
							end
						end
						default: ;
					endcase
				end
				`CLJM_A_TARGET:  n.target = WDATA;
				`CLJM_A_POS: begin
					n.pos = WDATA;
					n.imode = `CLJM_IDX_OFF;
					n.ifound = 1'b0;
					n.qoff = 32'h0000_0000;
				end
				`CLJM_A_LOWER:   n.lower = WDATA;
				`CLJM_A_UPPER:   n.upper = WDATA;
				`CLJM_A_ENCDIR:  n.encdir = WDATA[0];
				`CLJM_A_ACCEL:   n.accel = WDATA[15:0];
				`CLJM_A_DECEL:   n.decel = WDATA[15:0];
				`CLJM_A_SPC:     n.microsteps_per_encoder_count = WDATA;
				`CLJM_A_SLOW:    n.slow = WDATA[1:0];
				`CLJM_A_ENCTYPE: n.enctype = WDATA[1:0];
				`CLJM_A_QOFF: begin
					n.qoff = WDATA;
					// keep the indexed reference, move the position with it
					if (s.imode == `CLJM_IDX_DONE)
						n.pos = n.pos - s.qoff + WDATA;
				end
				`CLJM_A_SCRIPT: begin
					if (WDATA[0] && s.sc == cljm_pkg::SC_IDLE) begin
						n.sc = cljm_pkg::SC_FWD;
						n.scstat = 8'h01;
						n.p0 = s.pos;
						n.tmode = 1'b0;
						n.rem = `CLJM_SCRIPT_USTEPS;
						n.dir = 1'b0;
						n.rate = `CLJM_SCRIPT_RATE;
						n.acc = 32'h0000_0000;
					end
				end
				`CLJM_A_JWFM: begin
					n.jwfm = WDATA;
					n.jmicro = 32'h0000_0000;
				end
				`CLJM_A_JMICRO:  n.jmicro = WDATA;
				`CLJM_A_JSPEED:  n.jspeed = WDATA;
				`CLJM_A_IMODE: begin
					// only the three documented codes are taken
					if (WDATA[2:0] == `CLJM_IDX_OFF || WDATA[2:0] == `CLJM_IDX_STOP
						|| WDATA[2:0] == `CLJM_IDX_RESET) begin
						n.imode = WDATA[2:0];
						n.ifound = 1'b0;
					end
				end
				default: ;
			endcase
		end

		// -------------------------------------------------------
		// register reads, data in the following cycle
		// -------------------------------------------------------
		if (RD) begin
			case (ADDR)
				`CLJM_A_TARGET:  n.rdata = s.target;
				`CLJM_A_POS:     n.rdata = s.pos;
				`CLJM_A_LOWER:   n.rdata = s.lower;
				`CLJM_A_UPPER:   n.rdata = s.upper;
				`CLJM_A_ENCDIR:  n.rdata = {31'h0, s.encdir};
				`CLJM_A_ACCEL:   n.rdata = {16'h0000, s.accel};
				`CLJM_A_DECEL:   n.rdata = {16'h0000, s.decel};
				`CLJM_A_SPC:     n.rdata = s.microsteps_per_encoder_count;
				`CLJM_A_SLOW:    n.rdata = {30'h0, s.slow};
				`CLJM_A_ENCTYPE: n.rdata = {30'h0, s.enctype};
				`CLJM_A_QOFF:    n.rdata = s.qoff;
				`CLJM_A_SCRIPT:  n.rdata = {{24{s.scstat[7]}}, s.scstat};
				`CLJM_A_JWFM:    n.rdata = s.jwfm;
				`CLJM_A_JMICRO:  n.rdata = s.jmicro;
				`CLJM_A_JSPEED:  n.rdata = s.jspeed;
				`CLJM_A_IMODE: begin
					n.rdata = {23'h0, s.ifresh, 5'h00, s.imode};
					n.ifresh = 1'b0;
				end
				`CLJM_A_IPOS:    n.rdata = s.ipos;
				`CLJM_A_STATUS:  n.rdata = {16'h0000, digits};
				`CLJM_A_COMBO:   n.rdata = {8'h00, digits, IO_PINS};
				`CLJM_A_LOAD:    n.rdata = {WAVE_RHOMB, FREQ_HZ, CAP_NF};
				default:         n.rdata = 32'h0000_0000;
			endcase
		end

		// a capture in the clearing cycle survives the read
		if (irise)
			n.ifresh = 1'b1;
	end

	// -----------------------------------------------------------
	// state register
	// -----------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			s <= '0;
			s.lower <= `CLJM_RST_LOWER;
			s.upper <= `CLJM_RST_UPPER;
			s.accel <= `CLJM_RST_ACCEL;
			s.decel <= `CLJM_RST_DECEL;
			s.microsteps_per_encoder_count <= `CLJM_RST_SPC;
			s.jspeed <= `CLJM_RST_JSPEED;
			s.sc <= cljm_pkg::SC_IDLE;
		end else begin
			s <= n;
		end
	end

	// outputs straight from the state flops
	assign RDATA = s.rdata;
	assign MICRO_STEP = s.step;
	assign MOTOR_DIR = s.dir;
	assign MOTOR_RUN = s.run;
	assign TARGET_MODE = s.tmode;

endmodule

// ===== logic/cljm_defines.svh
// constants for the closed loop, index and jog motion core
`ifndef CLJM_DEFINES_SVH
`define CLJM_DEFINES_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLJM_CLK_HZ 200000000
`define CLJM_LOOP_MS 1
`define CLJM_SLOW_LOOP_MS 2
`define CLJM_LOOP_CYC (`CLJM_CLK_HZ / 1000 * `CLJM_LOOP_MS)
`define CLJM_SLOW_CYC (`CLJM_CLK_HZ / 1000 * `CLJM_SLOW_LOOP_MS)
`define CLJM_STEP_THRESH 32'd200000000

// ---------------------------------------------------------------
// motion scaling
// ---------------------------------------------------------------
`define CLJM_USTEP_SHIFT 13
`define CLJM_SPC_SHIFT 5
`define CLJM_SCRIPT_WFM 16
`define CLJM_SCRIPT_USTEPS 32'h0002_0000
`define CLJM_DIV_MSB 5'd22
`define CLJM_SCRIPT_RATE 16'h0040
`define CLJM_SPC_FAIL 32'h0000_0001

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CLJM_A_CMD 8'h00
`define CLJM_A_TARGET 8'h04
`define CLJM_A_POS 8'h08
`define CLJM_A_LOWER 8'h0C
`define CLJM_A_UPPER 8'h10
`define CLJM_A_ENCDIR 8'h14
`define CLJM_A_ACCEL 8'h18
`define CLJM_A_DECEL 8'h1C
`define CLJM_A_SPC 8'h20
`define CLJM_A_SLOW 8'h24
`define CLJM_A_ENCTYPE 8'h28
`define CLJM_A_QOFF 8'h2C
`define CLJM_A_SCRIPT 8'h30
`define CLJM_A_JWFM 8'h34
`define CLJM_A_JMICRO 8'h38
`define CLJM_A_JSPEED 8'h3C
`define CLJM_A_IMODE 8'h40
`define CLJM_A_IPOS 8'h44
`define CLJM_A_STATUS 8'h48
`define CLJM_A_COMBO 8'h4C
`define CLJM_A_LOAD 8'h50

// ---------------------------------------------------------------
// codes and reset values
// ---------------------------------------------------------------
`define CLJM_CMD_ABS 3'h1
`define CLJM_CMD_REL 3'h2
`define CLJM_CMD_CONT 3'h3
`define CLJM_CMD_STOP 3'h4
`define CLJM_CMD_JOG 3'h5
`define CLJM_CMD_IJOG 3'h6
`define CLJM_IDX_OFF 3'h0
`define CLJM_IDX_DONE 3'h1
`define CLJM_IDX_STOP 3'h2
`define CLJM_IDX_RESET 3'h4
`define CLJM_ENC_QUAD 2'h0
`define CLJM_ENC_SLOW 2'h3
`define CLJM_RST_LOWER 32'h8000_0000
`define CLJM_RST_UPPER 32'h7FFF_FFFF
`define CLJM_RST_ACCEL 16'h0010
`define CLJM_RST_DECEL 16'h0010
`define CLJM_RST_SPC 32'h0000_00FA
`define CLJM_RST_JSPEED 32'h0000_0100

`endif

// ===== logic/cljm_pkg.sv
// types for the closed loop, index and jog motion core
package cljm_pkg;

	// script sequencer, gray along idle-fwd-rev-calc
	typedef enum logic [1:0] {
		SC_IDLE = 2'b00,
		SC_FWD  = 2'b01,
		SC_REV  = 2'b11,
		SC_CALC = 2'b10
	} cljm_script_e;

	// whole state of the core
	typedef struct packed {
		logic [31:0]  rdata;
		logic [2:0]   sy1;
		logic [2:0]   sy2;
		logic [1:0]   pab;
		logic         pidx;
		logic [31:0]  pos;
		logic [31:0]  target;
		logic         tmode;
		logic         treached;
		logic         tlimit;
		logic [31:0]  lower;
		logic [31:0]  upper;
		logic         encdir;
		logic [15:0]  accel;
		logic [15:0]  decel;
		logic [31:0]  microsteps_per_encoder_count;
		logic [1:0]   slow;
		logic [1:0]   enctype;
		logic [31:0]  qoff;
		logic [31:0]  jwfm;
		logic [31:0]  jmicro;
		logic [31:0]  jspeed;
		logic [2:0]   imode;
		logic         ifound;
		logic [31:0]  ipos;
		logic         ifresh;
		logic [31:0]  rem;
		logic         dir;
		logic [15:0]  rate;
		logic [31:0]  acc;
		logic [31:0]  vel;
		logic [19:0]  tick;
		logic         step;
		logic         run;
		cljm_script_e sc;
		logic [7:0]   scstat;
		logic [31:0]  p0;
		logic [31:0]  dmag;
		logic [31:0]  dr;
		logic [31:0]  dq;
		logic [4:0]   dcnt;
	} cljm_state_s;

endpackage

// ===== testbench/cljm_motion_monitor.sv
// port assertions for the motion core
`timescale 1ns/1ps
module cljm_motion_monitor (
	input wire logic        CLK,
	input wire logic        RST_B,
	input wire logic [7:0]  ADDR,
	input wire logic [31:0] WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [31:0] RDATA,
	input wire logic [15:0] CAP_NF,
	input wire logic [14:0] FREQ_HZ,
	input wire logic        WAVE_RHOMB,
	input wire logic [7:0]  IO_PINS,
	input wire logic        MICRO_STEP,
	input wire logic        MOTOR_DIR,
	input wire logic        TARGET_MODE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// ----------------------------------------
	// bus answers
	// ----------------------------------------
	property p_rd_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_unmapped; RD && ADDR > 8'h50 |=> RDATA == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_load;
		RD && ADDR == 8'h50 |=> RDATA == {$past(WAVE_RHOMB), $past(FREQ_HZ), $past(CAP_NF)};
	endproperty
	a_load: assert property (p_load) else $error("load word wrong");
	property p_combo;
		RD && ADDR == 8'h4C |=> RDATA[7:0] == $past(IO_PINS) && RDATA[31:24] == 8'h0;
	endproperty
	a_combo: assert property (p_combo) else $error("combined word wrong");
	property p_limrb; WR && ADDR == 8'h0C ##1 RD && ADDR == 8'h0C |=> RDATA == $past(WDATA, 2);
	endproperty
	a_limrb: assert property (p_limrb) else $error("lower limit lost");
	// ----------------------------------------
	// modes and motion
	// ----------------------------------------
	property p_tenter; WR && ADDR == 8'h00 && WDATA[2:0] inside {3'h1, 3'h2, 3'h3} |=> TARGET_MODE;
	endproperty
	a_tenter: assert property (p_tenter) else $error("target run left loop off");
	property p_tleave; WR && ADDR == 8'h00 && WDATA[2:0] inside {3'h4, 3'h5, 3'h6} |=> !TARGET_MODE;
	endproperty
	a_tleave: assert property (p_tleave) else $error("loop still on");
	property p_dir; MICRO_STEP ##1 MICRO_STEP |-> $stable(MOTOR_DIR); endproperty
	a_dir: assert property (p_dir) else $error("direction flipped mid move");
	property p_unidx; WR && ADDR == 8'h08 ##1 RD && ADDR == 8'h40 |=> RDATA[2:0] == 3'h0;
	endproperty
	a_unidx: assert property (p_unidx) else $error("still indexed");
	property p_qoff; WR && ADDR == 8'h08 ##1 RD && ADDR == 8'h2C |=> RDATA == 32'h0; endproperty
	a_qoff: assert property (p_qoff) else $error("offset not cleared");
	c_step: cover property (MICRO_STEP);
	c_tmode: cover property ($rose(TARGET_MODE));
	c_unm: cover property (RD && ADDR > 8'h50);
endmodule
bind cljm_motion cljm_motion_monitor mon_u (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CAP_NF(CAP_NF), .FREQ_HZ(FREQ_HZ),
	.WAVE_RHOMB(WAVE_RHOMB), .IO_PINS(IO_PINS), .MICRO_STEP(MICRO_STEP),
	.MOTOR_DIR(MOTOR_DIR), .TARGET_MODE(TARGET_MODE));

// ===== testbench/cljm_enc_model.sv
// encoder stand-in for the motion core
`timescale 1ns/1ps
module cljm_enc_model (
	input  wire logic   CLK,
	input  wire logic   RST_B,
	input  wire logic   MARK,
	output logic        QUAD_A,
	output logic        QUAD_B,
	output logic        QUAD_I,
	output logic [31:0] ENC_WORD,
	output logic        ENC_WORD_VALID
);
	logic [2:0] ph;
	// one homing pass in gray steps; A and B stay high after it until the next mark
	// so that no count lands after the index reset
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ph <= 3'h0;
			ENC_WORD <= 32'h0;
		end else begin
			if (MARK || (ph != 3'h0 && ph != 3'h7)) begin
				ph <= ph + 3'h1;
			end
			// each mark moves the serial reading on, so a handed word is known
			if (MARK) begin
				ENC_WORD <= ENC_WORD + 32'h0000_0100;
			end
		end
	end
	assign QUAD_A = ph >= 3'h1;
	assign QUAD_B = ph >= 3'h2;
	assign QUAD_I = ph >= 3'h3 && ph <= 3'h5;
	// the quadrature path ignores the word, so one mark serves both sources
	assign ENC_WORD_VALID = MARK;
endmodule

// ===== testbench/tb_cljm_motion.sv
// self-checking bench for the motion core
`timescale 1ns/1ps
module tb_cljm_motion;
	localparam int LOOP = 50;
	logic        CLK = 1'b0;
	logic        RST_B = 1'b0;
	logic [7:0]  ADDR = 8'h0;
	logic [31:0] WDATA = 32'h0;
	logic        WR = 1'b0;
	logic        RD = 1'b0;
	logic [15:0] CAP_NF = 16'h0810;
	logic [14:0] FREQ_HZ = 15'h01C9;
	logic        WAVE_RHOMB = 1'b1;
	logic [7:0]  IO_PINS = 8'hDC;
	logic        MARK = 1'b0;
	logic [31:0] RDATA, ENC_WORD, v, st;
	logic        QUAD_A, QUAD_B, QUAD_I, ENC_WORD_VALID;
	logic        MICRO_STEP, MOTOR_DIR, MOTOR_RUN, TARGET_MODE;
	int          mismatches = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          nst = 0;
	int          ccnt = 0;
	int          rise_at = 0;
	int          rise_gap = 0;
	logic        mprev = 1'b0;
	logic [7:0]  ra [7] = '{8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20, 8'h3C, 8'h54};
	logic [31:0] rv [7] = '{32'h8000_0000, 32'h7FFF_FFFF, 32'h10, 32'h10, 32'hFA, 32'h100, 32'h0};
	logic [2:0]  tc [6] = '{3'h1, 3'h4, 3'h2, 3'h5, 3'h3, 3'h4};
	logic        tm [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	logic [31:0] jw [3] = '{32'h0, 32'h0, 32'hFFFF_FFFF};
	logic [31:0] js [3] = '{32'h6000, 32'hFFFF_A000, 32'h0};
	int          jn [3] = '{16, 16, 8192};
	logic        jd [3] = '{1'b0, 1'b1, 1'b0};

	always #2.5 CLK = ~CLK;
	always @(posedge CLK) if (MICRO_STEP === 1'b1) nst++;
	// cycles between rising step pulses, to time the loop bursts
	always @(posedge CLK) begin
		ccnt <= ccnt + 1;
		mprev <= MICRO_STEP;
		if (MICRO_STEP === 1'b1 && mprev !== 1'b1) begin
			rise_gap <= ccnt - rise_at;
			rise_at <= ccnt;
		end
	end

	cljm_motion #(.LOOP_CYCLES(LOOP), .SLOW_CYCLES(2 * LOOP)) dut_u (.CLK(CLK), .RST_B(RST_B),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .QUAD_A(QUAD_A),
		.QUAD_B(QUAD_B), .QUAD_I(QUAD_I), .ENC_WORD(ENC_WORD), .ENC_WORD_VALID(ENC_WORD_VALID),
		.CAP_NF(CAP_NF), .FREQ_HZ(FREQ_HZ), .WAVE_RHOMB(WAVE_RHOMB), .IO_PINS(IO_PINS),
		.MICRO_STEP(MICRO_STEP), .MOTOR_DIR(MOTOR_DIR), .MOTOR_RUN(MOTOR_RUN),
		.TARGET_MODE(TARGET_MODE));
	cljm_enc_model enc_u (.CLK(CLK), .RST_B(RST_B), .MARK(MARK), .QUAD_A(QUAD_A),
		.QUAD_B(QUAD_B), .QUAD_I(QUAD_I), .ENC_WORD(ENC_WORD), .ENC_WORD_VALID(ENC_WORD_VALID));

	// ----------------------------------------
	// bus tasks, entered right after a rising edge
	// ----------------------------------------
	// a write straight after a write waits one edge so WR is never set twice at once
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		if (WR === 1'b1) @(posedge CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CLK);
		RD <= 1'b0;
		@(negedge CLK);
		d = RDATA;
		@(posedge CLK);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a, v);
		chk(v, e);
	endtask
	// bounded wait for the motor to stop, then let the last pulse be counted
	task automatic waitrun();
		for (int i = 0; i < 20000 && MOTOR_RUN !== 1'b0; i++) @(posedge CLK);
		repeat (2) @(posedge CLK);
	endtask
	task automatic final_report();
		if (mismatches == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	always @(posedge CLK) begin
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			final_report();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge CLK);
		RST_B <= 1'b1;
		@(posedge CLK);
		foreach (ra[i]) rchk(ra[i], rv[i]);
		rchk(8'h50, {WAVE_RHOMB, FREQ_HZ, CAP_NF});
		rd(8'h48, st);
		chk(st, 32'h0);
		rchk(8'h4C, {8'h0, st[15:0], IO_PINS});
		// homing: a bad code is refused, then reset at index
		wr(8'h40, 32'h3);
		rchk(8'h40, 32'h0);
		wr(8'h40, 32'h4);
		wr(8'h2C, 32'h55);
		MARK <= 1'b1;
		@(posedge CLK);
		MARK <= 1'b0;
		repeat (12) @(posedge CLK);
		rchk(8'h40, 32'h101);
		rchk(8'h40, 32'h1);
		rchk(8'h08, 32'h55);
		wr(8'h2C, 32'h60);
		rchk(8'h08, 32'h60);
		// serial source: one mark pulse hands one word over
		wr(8'h28, 32'h1);
		MARK <= 1'b1;
		@(posedge CLK);
		MARK <= 1'b0;
		rchk(8'h08, 32'h100);
		wr(8'h28, 32'h0);
		wr(8'h08, 32'h200);
		rchk(8'h40, 32'h0);
		wr(8'h08, 32'h200);
		rchk(8'h2C, 32'h0);
		// each target run command, stop and plain jog against the loop flag
		foreach (tc[i]) begin
			wr(8'h00, {29'h0, tc[i]});
			@(negedge CLK);
			chk({31'h0, TARGET_MODE}, {31'h0, tm[i]});
			@(posedge CLK);
		end
		// jog table; the last row reuses the reversed speed
		foreach (jw[i]) begin
			waitrun();
			nst = 0;
			wr(8'h34, jw[i]);
			wr(8'h38, jn[i] == 8192 ? 32'h0 : 32'h10);
			if (js[i] != 32'h0) wr(8'h3C, js[i]);
			wr(8'h00, 32'h5);
			repeat (2) @(negedge CLK);
			chk({31'h0, MOTOR_DIR}, {31'h0, jd[i]});
			@(posedge CLK);
			waitrun();
			chk(nst, jn[i]);
		end
		wr(8'h00, 32'h6);
		repeat (2) @(negedge CLK);
		chk({31'h0, MOTOR_RUN}, 32'h0);
		@(posedge CLK);
		wr(8'h40, 32'h2);
		wr(8'h00, 32'h6);
		repeat (2) @(negedge CLK);
		chk({31'h0, MOTOR_RUN}, 32'h1);
		@(posedge CLK);
		waitrun();
		// bursts start one period apart, twice as far on the slow serial type;
		// a small accel keeps every burst shorter than the period
		wr(8'h18, 32'h4);
		wr(8'h04, 32'h400);
		for (int e = 0; e < 2; e++) begin
			wr(8'h28, e == 0 ? 32'h0 : 32'h3);
			wr(8'h00, 32'h1);
			repeat (4 * LOOP * (e + 1)) @(posedge CLK);
			chk(rise_gap, (e + 1) * LOOP);
			wr(8'h00, 32'h4);
		end
		wr(8'h28, 32'h0);
		// position below the lower limit drops the loop at a tick
		wr(8'h0C, 32'h300);
		rchk(8'h0C, 32'h300);
		wr(8'h00, 32'h1);
		for (int i = 0; i < 3 * LOOP && (i == 0 || TARGET_MODE === 1'b1); i++) @(negedge CLK);
		@(posedge CLK);
		chk({31'h0, TARGET_MODE}, 32'h0);
		rd(8'h48, st);
		chk({31'h0, st[6]}, 32'h1);
		// the scale script reports running; it is too slow to finish here
		wr(8'h30, 32'h1);
		rchk(8'h30, 32'h1);
		rd(8'h48, st);
		chk({31'h0, st[9]}, 32'h1);
		final_report();
	end
endmodule
